// ===== csrc_partner.sv
/* External reset source and serial bit clock master.
 * Assumes the bench commands clock run, slow rate and reset pin level. */
`timescale 1ns/10ps
module csrc_partner (
	// Commands from the bench
	input wire logic run,
	input wire logic slow,
	input wire logic rst_req_n,
	// Pins towards the device
	output logic ext_power_up_reset_n,
	output logic serial_bit_clock_in = 1'h0
);
	// Reset pin follows the request level
	assign ext_power_up_reset_n = rst_req_n;
	// Bit clock stands low outside frames; slow rate breaks the edge gap limit
	always begin
		#(slow ? 56000 : 320);
		serial_bit_clock_in = run & ~serial_bit_clock_in;
	end
endmodule

// ===== csrc_pkg.sv
/*
 * Constants, types and state layout of the clock source and reset control block.
 * Assumes a single 25 MHz system clock; the watchdog and software control
 * ports run on that same clock.
 */
// Notes on behaviour
// - The PLL uses exactly one reference: serial bit clock or crystal oscillator.
// - Reference choice starts from the reference strap; software may change it later.
// - Works without oscillator when bit clock is stable; external clock may replace oscillator.
// - PLL drives processor clock, and codec clock when no oscillator is present.
// - In master mode the driven serial clock may come from the PLL.
// - PLL locks to references down to 44 KHz; higher gives lower jitter.
// - One reset domain: every reset source resets the same logic.
// - A watchdog event raises a watchdog reset.
// - Low external reset pin raises a power-up reset.
// - During power-up reset strap pins float with their pull resistors enabled.
// - Strap levels are captured after reset pin release and used as configuration.
// - Power-up reset also does everything a watchdog reset does.
// - Internal reset stays active at least 3 ms for any reset.
// - Watchdog reset returns every register to its default value; the code resets only PLL config and reference choice, keeping captured straps.
package csrc_pkg;

	// Clock rate and times in their own units
	localparam int CSRC_CLK_HZ = 25000000;
	localparam int CSRC_HOLD_MS = 3;
	localparam int CSRC_REF_MIN_HZ = 44000;
	// Least hold time, rounded up to whole cycles
	localparam int CSRC_HOLD_CYC = (CSRC_HOLD_MS * CSRC_CLK_HZ + 999) / 1000;
	// Longest gap between bit clock rising edges at the slowest reference
	localparam int CSRC_REF_GAP_CYC = (CSRC_CLK_HZ + CSRC_REF_MIN_HZ - 1) / CSRC_REF_MIN_HZ;

	// Widths
	localparam int CSRC_CNT_W = 17;
	localparam int CSRC_GAP_W = 10;
	localparam int CSRC_EDGE_W = 4;
	localparam int CSRC_STRAP_W = 2;
	localparam int CSRC_MULT_W = 8;
	localparam int CSRC_DIV_W = 6;

	// Strap positions and bit clock stability threshold
	localparam int CSRC_STRAP_REF = 0;
	localparam logic [CSRC_EDGE_W-1:0] CSRC_STABLE_EDGES = 4'hF;
	localparam logic [CSRC_GAP_W-1:0] CSRC_GAP_MAX = CSRC_GAP_W'(CSRC_REF_GAP_CYC);

	// Clock generation parameters and their defaults
	typedef struct packed {
		logic [CSRC_MULT_W-1:0] mult;
		logic [CSRC_DIV_W-1:0] div;
		logic ssp_clk_en;
	} csrc_pll_cfg_s;
	localparam csrc_pll_cfg_s CSRC_PLL_CFG_RST = '{mult: 8'h01, div: 6'h01, ssp_clk_en: 1'b0};

	// Routing of the generated clocks
	typedef struct packed {
		logic ref_bitclk;
		logic proc_from_pll;
		logic codec_from_pll;
		logic ssp_from_pll;
	} csrc_route_s;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_PWRUP = 4'h1,
		ST_SAMPLE = 4'h2,
		ST_HOLD = 4'h4,
		ST_RUN = 4'h8
	} csrc_state_e;

	// Whole state of the block
	typedef struct packed {
		logic [2:0] pin_sync;
		logic pin_n;
		logic [2:0] bclk_sync;
		logic [2:0] strap_s1;
		logic [2:0] strap_s2;
		logic [2:0] strap_s3;
		csrc_state_e st;
		logic [CSRC_CNT_W-1:0] cnt;
		logic [CSRC_GAP_W-1:0] gap;
		logic [CSRC_EDGE_W-1:0] edges;
		logic bclk_stable;
		logic [CSRC_STRAP_W-1:0] strap_val;
		logic ref_req_bitclk;
		csrc_pll_cfg_s cfg;
		csrc_route_s route;
		logic int_rst;
		logic strap_float;
		logic [CSRC_STRAP_W-1:0] strap_out;
		logic [CSRC_STRAP_W-1:0] strap_oe;
	} csrc_regs_s;

endpackage

// ===== csrc_properties.sv
/* Timing checks on the clock source and reset control block ports.
 * Assumes one mclk domain and bind from the testbench top. */
`timescale 1ns/10ps
module csrc_properties import csrc_pkg::*; #(
	parameter int HOLD_CYC = CSRC_HOLD_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Watched inputs
	input wire logic ext_power_up_reset_n,
	input wire logic wdt_event,
	input wire logic sync_serial_port_master,
	input wire logic osc_present,
	input wire logic pll_cfg_we,
	input wire csrc_pll_cfg_s pll_cfg_in,
	input wire logic [CSRC_STRAP_W-1:0] strap_func_oe,
	// Watched outputs
	input wire logic [CSRC_STRAP_W-1:0] strap_oe,
	input wire logic strap_pull_en,
	input wire logic int_rst,
	input wire logic [CSRC_STRAP_W-1:0] strap_cfg,
	input wire logic bclk_stable,
	input wire csrc_pll_cfg_s pll_cfg,
	input wire csrc_route_s clk_route
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [CSRC_CNT_W-1:0] hcnt_r;
	// Length of the current internal reset; too long a hold is harmless
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			hcnt_r <= '0;
		else
			hcnt_r <= int_rst ? CSRC_CNT_W'(hcnt_r + 1'b1) : '0;
	end
	a_hold_min: assert property (!int_rst && $past(int_rst) |-> hcnt_r >= HOLD_CYC)
		else $error("internal reset released early");
	a_wdt_entry: assert property (wdt_event && !int_rst |=> int_rst && pll_cfg == CSRC_PLL_CFG_RST)
		else $error("watchdog did not reset");
	a_pin_rst: assert property (!ext_power_up_reset_n [*6] |-> int_rst && strap_pull_en && strap_oe == 2'h0)
		else $error("pin reset not applied to straps");
	a_func_drive: assert property (!int_rst && $past(!int_rst) |-> strap_oe == $past(strap_func_oe) && !strap_pull_en)
		else $error("strap drive wrong in run");
	a_strap_kept: assert property (!int_rst |-> $stable(strap_cfg))
		else $error("strap values changed in run");
	a_cfg_load: assert property (pll_cfg_we && !int_rst && !wdt_event |=> pll_cfg == $past(pll_cfg_in))
		else $error("pll config not loaded");
	a_proc_codec: assert property (!int_rst && $past(!int_rst) |-> clk_route.proc_from_pll && clk_route.codec_from_pll == !$past(osc_present))
		else $error("processor or codec route wrong");
	a_ssp_route: assert property (!int_rst && $past(!int_rst) && $stable(pll_cfg) |-> clk_route.ssp_from_pll == $past(sync_serial_port_master && pll_cfg.ssp_clk_en))
		else $error("serial clock route wrong");
	a_ref_legal: assert property (clk_route.ref_bitclk |-> $past(!sync_serial_port_master) && (bclk_stable || $past(bclk_stable)))
		else $error("bit clock used as reference illegally");
	c_wdt: cover property (wdt_event && !int_rst);
	c_release: cover property ($fell(int_rst));
	c_stable: cover property ($rose(bclk_stable));
endmodule

// ===== csrc_top.sv
/*
 * Clock source selection and reset sequencer.
 * Holds the strap sampling, the internal reset hold, the bit clock activity
 * monitor and the PLL reference and clock routing selects.
 * Assumes the PLL, clock muxes and pads sit outside and obey the selects;
 * the watchdog and software ports are synchronous to mclk.
 */
`timescale 1ns/10ps
module csrc_top import csrc_pkg::*; #(
	parameter int HOLD_CYC = CSRC_HOLD_CYC
) (
	// Clock and raw reset
	input wire logic mclk,
	input wire logic sys_rst,
	// External power-up reset pin
	input wire logic ext_power_up_reset_n,
	// Watchdog event, one cycle
	input wire logic wdt_event,
	// Serial bit clock pin and port mode
	input wire logic serial_bit_clock_in,
	input wire logic sync_serial_port_master,
	input wire logic osc_present,
	// Software control
	input wire logic sw_ref_we,
	input wire logic sw_ref_bitclk,
	input wire logic pll_cfg_we,
	input wire csrc_pll_cfg_s pll_cfg_in,
	// Strap pins and their functional drive
	input wire logic [CSRC_STRAP_W-1:0] strap_in,
	input wire logic [CSRC_STRAP_W-1:0] strap_func_out,
	input wire logic [CSRC_STRAP_W-1:0] strap_func_oe,
	output logic [CSRC_STRAP_W-1:0] strap_out,
	output logic [CSRC_STRAP_W-1:0] strap_oe,
	output logic strap_pull_en,
	// Reset and clock controls
	output logic int_rst,
	output logic [CSRC_STRAP_W-1:0] strap_cfg,
	output logic bclk_stable,
	output csrc_pll_cfg_s pll_cfg,
	output csrc_route_s clk_route
);

	localparam logic [CSRC_CNT_W-1:0] HOLD_LAST = CSRC_CNT_W'(HOLD_CYC - 1);

	csrc_regs_s r;
	csrc_regs_s nxt;

	// Reference is the bit clock only when slave mode and the clock is alive
	function automatic logic pick_bitclk(input logic want, input logic master, input logic alive);
		pick_bitclk = want & ~master & alive;
	endfunction

	// Next-state logic of the whole block
	always_comb begin
		logic bclk_rise;
		logic pin_agree;
		logic strap_agree;
		logic rst_now;
		bclk_rise = 1'b0;
		pin_agree = 1'b0;
		strap_agree = 1'b0;
		rst_now = 1'b0;
		nxt = r;

		// Three-flop synchronisers; the first stage feeds only the second
		nxt.pin_sync = {r.pin_sync[1:0], ext_power_up_reset_n};
		nxt.bclk_sync = {r.bclk_sync[1:0], serial_bit_clock_in};
		nxt.strap_s1 = {1'b0, strap_in};
		nxt.strap_s2 = r.strap_s1;
		nxt.strap_s3 = r.strap_s2;
		pin_agree = (r.pin_sync[1] == r.pin_sync[2]);
		strap_agree = (r.strap_s2 == r.strap_s3);
		if (pin_agree) begin
			nxt.pin_n = r.pin_sync[2];
		end

		// Bit clock monitor: a rising edge within the slowest period keeps it alive
		bclk_rise = r.bclk_sync[1] & ~r.bclk_sync[2];
		if (bclk_rise) begin
			nxt.gap = '0;
			if (r.edges != CSRC_STABLE_EDGES) begin
				nxt.edges = r.edges + 1'b1;
			end
		end else if (r.gap == CSRC_GAP_MAX) begin
			// Too slow or stopped: not usable as reference
			nxt.edges = '0;
		end else begin
			nxt.gap = r.gap + 1'b1;
		end
		nxt.bclk_stable = (nxt.edges == CSRC_STABLE_EDGES);

		// Reset sequencer
		case (r.st)
			ST_PWRUP: begin
				// Pin low keeps us here; release leads to strap capture
				if (r.pin_n) begin
					nxt.st = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				// Capture only once the strap synchroniser has settled
				if (strap_agree) begin
					nxt.strap_val = r.strap_s3[CSRC_STRAP_W-1:0];
					nxt.st = ST_HOLD;
					nxt.cnt = '0;
				end
			end
			ST_HOLD: begin
				if (r.cnt == HOLD_LAST) begin
					nxt.st = ST_RUN;
				end else begin
					nxt.cnt = r.cnt + 1'b1;
				end
			end
			ST_RUN: begin
				nxt.cnt = '0;
			end
			default: begin
				nxt.st = ST_PWRUP;
			end
		endcase

		// Watchdog restarts the hold; power-up reset overrides everything
		if (wdt_event && r.st != ST_PWRUP && r.st != ST_SAMPLE) begin
			nxt.st = ST_HOLD;
			nxt.cnt = '0;
		end
		if (!r.pin_n) begin
			nxt.st = ST_PWRUP;
			nxt.cnt = '0;
		end

		// Both reset types pass through the same hold into one reset line
		rst_now = (nxt.st != ST_RUN);
		nxt.int_rst = rst_now;

		// Registers take defaults while in reset, the reference from the strap
		if (rst_now) begin
			nxt.cfg = CSRC_PLL_CFG_RST;
			nxt.ref_req_bitclk = nxt.strap_val[CSRC_STRAP_REF];
		end else begin
			if (sw_ref_we) begin
				nxt.ref_req_bitclk = sw_ref_bitclk;
			end
			if (pll_cfg_we) begin
				nxt.cfg = pll_cfg_in;
			end
		end

		// Clock routing; a dead bit clock falls back to the oscillator
		nxt.route.ref_bitclk = pick_bitclk(nxt.ref_req_bitclk, sync_serial_port_master,
			nxt.bclk_stable);
		nxt.route.proc_from_pll = 1'b1;
		nxt.route.codec_from_pll = ~osc_present;
		nxt.route.ssp_from_pll = sync_serial_port_master & nxt.cfg.ssp_clk_en;

		// Strap pins float with pulls on until the strap levels are captured
		nxt.strap_float = (nxt.st == ST_PWRUP) || (nxt.st == ST_SAMPLE);
		nxt.strap_oe = nxt.strap_float ? '0 : strap_func_oe;
		nxt.strap_out = nxt.strap_float ? '0 : strap_func_out;
	end

	// State register; reset values are constants only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			r.pin_sync <= 3'h0;
			r.pin_n <= 1'b0;
			r.bclk_sync <= 3'h0;
			r.strap_s1 <= 3'h0;
			r.strap_s2 <= 3'h0;
			r.strap_s3 <= 3'h0;
			r.st <= ST_PWRUP;
			r.cnt <= '0;
			r.gap <= '0;
			r.edges <= '0;
			r.bclk_stable <= 1'b0;
			r.strap_val <= '0;
			r.ref_req_bitclk <= 1'b0;
			r.cfg <= CSRC_PLL_CFG_RST;
			r.route <= '0;
			r.int_rst <= 1'b1;
			r.strap_float <= 1'b1;
			r.strap_out <= '0;
			r.strap_oe <= '0;
		end else begin
			r <= nxt;
		end
	end

	// Outputs straight from the state register
	assign int_rst = r.int_rst;
	assign strap_out = r.strap_out;
	assign strap_oe = r.strap_oe;
	assign strap_pull_en = r.strap_float;
	assign strap_cfg = r.strap_val;
	assign bclk_stable = r.bclk_stable;
	assign pll_cfg = r.cfg;
	assign clk_route = r.route;

endmodule

// ===== csrc_top_tb.sv
/* Self-checking bench for the clock source and reset control block.
 * Assumes strap pins carry pulls that set their level while undriven. */
`timescale 1ns/10ps
module csrc_top_tb import csrc_pkg::*;;
	logic mclk = 1'h0, sys_rst = 1'h1, rst_req_n = 1'h0, wdt_event = 1'h0, master = 1'h0;
	logic osc = 1'h1, sw_we = 1'h0, sw_bit = 1'h0, cfg_we = 1'h0, run = 1'h0, slow = 1'h0;
	logic pin_n, bclk, int_rst, stab, pull_en;
	logic [1:0] pull = 2'h1, f_out = 2'h0, f_oe = 2'h0, s_out, s_oe, s_in, s_cfg;
	csrc_pll_cfg_s cfg_in = '0, pcfg;
	csrc_route_s route;
	int err_count = 0, n_tests = 0, seed = 32'h070B, i, w;
	// Pin level: device drive wins, else the pull
	assign s_in = (s_oe & s_out) | (~s_oe & pull);
	always #20 mclk = ~mclk;
	csrc_partner csrc_partner_inst (.run(run), .slow(slow), .rst_req_n(rst_req_n),
		.ext_power_up_reset_n(pin_n), .serial_bit_clock_in(bclk));
	csrc_top #(.HOLD_CYC(20)) csrc_top_inst (.mclk(mclk), .sys_rst(sys_rst),
		.ext_power_up_reset_n(pin_n), .wdt_event(wdt_event), .serial_bit_clock_in(bclk),
		.sync_serial_port_master(master), .osc_present(osc), .sw_ref_we(sw_we),
		.sw_ref_bitclk(sw_bit), .pll_cfg_we(cfg_we), .pll_cfg_in(cfg_in), .strap_in(s_in),
		.strap_func_out(f_out), .strap_func_oe(f_oe), .strap_out(s_out), .strap_oe(s_oe),
		.strap_pull_en(pull_en), .int_rst(int_rst), .strap_cfg(s_cfg), .bclk_stable(stab),
		.pll_cfg(pcfg), .clk_route(route));
	task tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task close_out;
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Waits out the internal reset, bounded, and checks its length
	task hold(input int m);
		w = 0;
		while (int_rst !== 1'h0 && w < 300) begin
			tick(1);
			w++;
		end
		chk("hold", 16'(w >= m && w < 300), 16'h1);
	endtask
	task pwr(input logic [1:0] p);
		pull = p;
		rst_req_n = 1'h0;
		tick(8);
		rst_req_n = 1'h1;
		hold(20);
		chk("strap", 16'(s_cfg), 16'(p));
		chk("cfg dflt", 16'(pcfg), 16'(CSRC_PLL_CFG_RST));
	endtask
	// Watchdog on the whole run
	initial begin
		#400000;
		err_count++;
		close_out;
	end
	initial begin
		tick(4);
		sys_rst = 1'h0;
		pwr(2'h1);
		run = 1'h1;
		tick(400);
		chk("bclk stable", 16'(stab), 16'h1);
		sw_bit = 1'h1;
		sw_we = 1'h1;
		tick(1);
		sw_we = 1'h0;
		tick(1);
		chk("ref bitclk", 16'(route.ref_bitclk), 16'h1);
		master = 1'h1;
		tick(2);
		chk("ref master", 16'(route.ref_bitclk), 16'h0);
		cfg_we = 1'h1;
		for (i = 0; i < 8; i++) begin
			cfg_in = csrc_pll_cfg_s'($random(seed));
			osc = $random(seed);
			master = $random(seed);
			f_oe = $random(seed);
			f_out = $random(seed);
			tick(1);
			chk("cfg load", 16'(pcfg), 16'(cfg_in));
			chk("codec", 16'(route.codec_from_pll), 16'(!osc));
			chk("strap oe", 16'(s_oe), 16'(f_oe));
			chk("strap out", 16'(s_out), 16'(f_out));
		end
		cfg_we = 1'h0;
		master = 1'h0;
		wdt_event = 1'h1;
		tick(1);
		wdt_event = 1'h0;
		chk("wdt rst", 16'(int_rst), 16'h1);
		chk("wdt cfg", 16'(pcfg), 16'(CSRC_PLL_CFG_RST));
		hold(19);
		chk("wdt strap", 16'(s_cfg), 16'h1);
		slow = 1'h1;
		tick(1500);
		chk("bclk dead", 16'(stab), 16'h0);
		chk("ref fallback", 16'(route.ref_bitclk), 16'h0);
		slow = 1'h0;
		pwr(2'h2);
		tick(400);
		chk("ref strap osc", 16'(route.ref_bitclk), 16'h0);
		close_out;
	end
endmodule
bind csrc_top csrc_properties #(.HOLD_CYC(HOLD_CYC)) csrc_properties_inst (.mclk, .sys_rst,
	.ext_power_up_reset_n, .wdt_event, .sync_serial_port_master, .osc_present, .pll_cfg_we,
	.pll_cfg_in, .strap_func_oe, .strap_oe, .strap_pull_en, .int_rst, .strap_cfg,
	.bclk_stable, .pll_cfg, .clk_route);
